// file: include/tx_ctl_pkg.sv
package tx_ctl_pkg;
  // ****************************************************************
  // Bus and register map
  // ****************************************************************
  localparam int          ADDR_W           = 4;
  localparam logic [3:0]  REG_CTRL         = 4'h0;
  localparam logic [3:0]  REG_BURST_MAX    = 4'h4;
  localparam logic [3:0]  REG_STATUS       = 4'h8;
  localparam logic [3:0]  REG_CAL_GROUP    = 4'hc;
  localparam logic [31:0] UNMAPPED_VALUE   = 32'h0000_0000;

  // CTRL fields
  localparam int          CTRL_PERMIT_BIT  = 0;
  // STATUS fields
  localparam int          STAT_XOFF_BIT    = 0;
  localparam int          STAT_FULL_BIT    = 1;
  localparam int          STAT_EMPTY_BIT   = 2;

  // ****************************************************************
  // Reset values and link word layout
  // ****************************************************************
  localparam logic [7:0]  BURST_MAX_RESET  = 8'h08;
  localparam int          WORD_W           = 64;
  localparam int          CAL_HI_BIT       = 55;
  localparam int          CAL_LO_BIT       = 40;
  localparam int          CAL_START_BIT    = 56;
  localparam int          BURST_FLAG_BIT   = 61;
  localparam int          CTRL_FLAG_BIT    = 63;
  localparam int          CAL_ENTRIES      = 256;
  localparam int          CAL_PER_WORD     = 16;
  localparam int          SEGMENTS         = 4;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_BCTRL = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_XOFF  = 4'b1000
  } tx_state_t;
endpackage

// file: hw/seg_fifo.sv
// ******************************************************************
// Small flop FIFO between user bus and word emitter
// ******************************************************************
module seg_fifo #(
  parameter int WIDTH = 66,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int PW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
    $error("seg_fifo depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr;
  logic [PW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty
  assign empty         = (wr_ptr == rd_ptr);
  assign full          = (wr_ptr[PW] != rd_ptr[PW]) &&
                         (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign in_ready_out  = !full;
  assign out_valid_out = !empty;
  assign push          = in_valid_in && !full;
  assign pop           = out_ready_in && !empty;
  assign out_data_out  = mem[rd_ptr[PW-1:0]];

  // Storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[PW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// file: hw/tx_control_word_insertion.sv
// Operation
// - Forced segment gets Burst Control before data
// - Four force inputs, each for own segment
// - Permit high sends data, low idles only
// - Permit low halts data, link XOFF
// - Calendar bit one XON, zero XOFF
// - Calendar has 256 entries from status
// - Calendar in bits 55:40, bit 56 first
// - Lowest entry on bit 55, descending
// - Later control words carry next 16 entries
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
module tx_control_word_insertion #(
  parameter int SEG_W      = 64,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic         clk_in,
  input  wire logic         reset_n_in,
  // Avalon-MM slave
  input  wire logic [3:0]   avs_address_in,
  input  wire logic         avs_read_in,
  input  wire logic         avs_write_in,
  input  wire logic [31:0]  avs_writedata_in,
  input  wire logic [3:0]   avs_byteenable_in,
  output logic      [31:0]  avs_readdata_out,
  output logic              avs_waitrequest_out,
  // User bus, four segments
  input  wire logic [3:0]   segment_valid_in,
  input  wire logic [255:0] segment_payload_in,
  input  wire logic         force_burst_ctrl_seg0_in,
  input  wire logic         force_burst_ctrl_seg1_in,
  input  wire logic         force_burst_ctrl_seg2_in,
  input  wire logic         force_burst_ctrl_seg3_in,
  output logic              user_ready_out,
  input  wire logic         transmit_permit_in,
  input  wire logic [255:0] flow_calendar_status_in,
  // Word stream to lanes
  output logic      [63:0]  link_word_out,
  output logic              link_is_ctrl_out,
  output logic              link_valid_out
);
  localparam int NSEG  = tx_ctl_pkg::SEGMENTS;
  localparam int ENT_W = SEG_W + 1;
  localparam int GRP_N = tx_ctl_pkg::CAL_ENTRIES / tx_ctl_pkg::CAL_PER_WORD;

  // One segment per link word, so the widths must agree
  if (SEG_W != tx_ctl_pkg::WORD_W) begin
    $error("segment width must equal link word width");
  end

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic        sw_permit;
  logic [7:0]  burst_max;
  logic        bus_done;
  logic [3:0]  cal_group;
  tx_ctl_pkg::tx_state_t state;
  tx_ctl_pkg::tx_state_t next_state;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  logic [31:0] ctrl_wr;
  logic [31:0] bmax_wr;

  // Byte lanes laid over the current value; only low bits are kept
  assign ctrl_wr = merge({31'h0000_0000, sw_permit}, avs_writedata_in,
                         avs_byteenable_in);
  assign bmax_wr = merge({24'h00_0000, burst_max}, avs_writedata_in,
                         avs_byteenable_in);

  // One wait cycle: request taken on second edge
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !bus_done;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bus_done <= 1'b0;
    end else begin
      bus_done <= (avs_read_in || avs_write_in) && !bus_done;
    end
  end

  // Writable control
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sw_permit <= 1'b1;
      burst_max <= tx_ctl_pkg::BURST_MAX_RESET;
    end else if (avs_write_in && bus_done) begin
      case (avs_address_in)
        tx_ctl_pkg::REG_CTRL: begin
          sw_permit <= ctrl_wr[tx_ctl_pkg::CTRL_PERMIT_BIT];
        end
        tx_ctl_pkg::REG_BURST_MAX: begin
          burst_max <= bmax_wr[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  logic fifo_full;
  logic fifo_empty;

  // Read mux; unmapped reads return zero
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && !bus_done) begin
      case (avs_address_in)
        tx_ctl_pkg::REG_CTRL:
          avs_readdata_out <= {31'h0000_0000, sw_permit};
        tx_ctl_pkg::REG_BURST_MAX:
          avs_readdata_out <= {24'h00_0000, burst_max};
        tx_ctl_pkg::REG_STATUS:
          avs_readdata_out <= {29'h0000_0000, fifo_empty, fifo_full,
                               state == tx_ctl_pkg::ST_XOFF};
        tx_ctl_pkg::REG_CAL_GROUP:
          avs_readdata_out <= {28'h000_0000, cal_group};
        default:
          avs_readdata_out <= tx_ctl_pkg::UNMAPPED_VALUE;
      endcase
    end
  end

  // ****************************************************************
  // Segment intake: serialise four segments into the FIFO
  // ****************************************************************
  logic [NSEG-1:0] force_seg;
  logic [NSEG-1:0] pend_valid;
  logic [NSEG-1:0] pend_force;
  logic [SEG_W-1:0] pend_data [NSEG];
  logic [1:0]      pick;
  logic            any_pend;
  logic            f_in_ready;
  logic            f_out_valid;
  logic            f_out_ready;
  logic [ENT_W-1:0] f_out_data;

  assign force_seg = {force_burst_ctrl_seg3_in, force_burst_ctrl_seg2_in,
                      force_burst_ctrl_seg1_in, force_burst_ctrl_seg0_in};
  assign any_pend  = |pend_valid;
  // New beat accepted only once previous beat fully queued
  assign user_ready_out = !any_pend;

  // Lowest pending segment goes first
  always_comb begin
    pick = 2'd0;
    for (int i = NSEG - 1; i >= 0; i--) begin
      if (pend_valid[i]) pick = 2'(i);
    end
  end

  // Each force bit travels with its own segment only
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pend_valid <= '0;
      pend_force <= '0;
    end else if (!any_pend) begin
      pend_valid <= segment_valid_in;
      pend_force <= force_seg & segment_valid_in;
    end else if (f_in_ready) begin
      pend_valid[pick] <= 1'b0;
    end
  end

  for (genvar g = 0; g < NSEG; g++) begin : g_seg
    always_ff @(posedge clk_in) begin
      if (!any_pend && segment_valid_in[g]) begin
        pend_data[g] <= segment_payload_in[g*SEG_W +: SEG_W];
      end
    end
  end

  seg_fifo #(
    .WIDTH (ENT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (any_pend),
    .in_ready_out  (f_in_ready),
    .in_data_in    ({pend_force[pick], pend_data[pick]}),
    .out_valid_out (f_out_valid),
    .out_ready_in  (f_out_ready),
    .out_data_out  (f_out_data)
  );
  assign fifo_full  = !f_in_ready;
  assign fifo_empty = !f_out_valid;

  // ****************************************************************
  // Word emitter
  // ****************************************************************
  logic [7:0] burst_cnt;
  logic       permit;
  logic       head_force;
  logic       need_bctrl;
  logic       force_served;

  assign permit     = transmit_permit_in && sw_permit;
  assign head_force = f_out_data[ENT_W-1];
  // Forced insertion not yet served, or burst at maximum length
  assign need_bctrl = (head_force && !force_served) ||
                      (burst_cnt >= burst_max);

  // A Burst Control word serves the head's force flag; without this
  // a forced head would ask for one forever and never be popped
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      force_served <= 1'b0;
    end else if (state == tx_ctl_pkg::ST_BCTRL) begin
      force_served <= 1'b1;
    end else if (f_out_ready) begin
      force_served <= 1'b0;
    end
  end

  // Data popped only in the data state
  assign f_out_ready = (state == tx_ctl_pkg::ST_DATA) && f_out_valid &&
                       permit && !need_bctrl;

  always_comb begin
    next_state = state;
    case (state)
      tx_ctl_pkg::ST_IDLE: begin
        if (!permit) next_state = tx_ctl_pkg::ST_XOFF;
        else if (f_out_valid) next_state = tx_ctl_pkg::ST_BCTRL;
      end
      tx_ctl_pkg::ST_BCTRL: begin
        next_state = permit ? tx_ctl_pkg::ST_DATA : tx_ctl_pkg::ST_XOFF;
      end
      tx_ctl_pkg::ST_DATA: begin
        if (!permit) next_state = tx_ctl_pkg::ST_XOFF;
        else if (!f_out_valid) next_state = tx_ctl_pkg::ST_IDLE;
        else if (need_bctrl) next_state = tx_ctl_pkg::ST_BCTRL;
      end
      tx_ctl_pkg::ST_XOFF: begin
        if (permit) next_state = tx_ctl_pkg::ST_IDLE;
      end
      default: next_state = tx_ctl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= tx_ctl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Burst length count, cleared by each Burst Control word
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      burst_cnt <= 8'h00;
    end else if (state == tx_ctl_pkg::ST_BCTRL) begin
      burst_cnt <= 8'h00;
    end else if (f_out_ready && burst_cnt != 8'hff) begin
      burst_cnt <= burst_cnt + 8'h01;
    end
  end

  // ****************************************************************
  // Calendar packing
  // ****************************************************************
  logic [15:0] cal_bits;

  // Group n: entry 16n on bit 55 down to 16n+15 on bit 40
  always_comb begin
    for (int i = 0; i < tx_ctl_pkg::CAL_PER_WORD; i++) begin
      // One bit per position: 1 XON, 0 XOFF
      cal_bits[tx_ctl_pkg::CAL_PER_WORD - 1 - i] =
        flow_calendar_status_in[{cal_group, 4'h0} + 8'(i)];
    end
  end

  logic emit_ctrl;
  assign emit_ctrl = (state != tx_ctl_pkg::ST_DATA) || !f_out_ready;

  // Each control word advances to the next 16 entries, then wraps
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      cal_group <= 4'h0;
    end else if (emit_ctrl) begin
      cal_group <= (32'(cal_group) == GRP_N - 1) ? 4'h0
                   : cal_group + 4'h1;
    end
  end

  // Registered output word; XOFF sends idle control words only
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      link_word_out    <= 64'h0000_0000_0000_0000;
      link_is_ctrl_out <= 1'b0;
      link_valid_out   <= 1'b0;
    end else begin
      link_valid_out <= 1'b1;
      if (!emit_ctrl) begin
        link_word_out    <= f_out_data[SEG_W-1:0];
        link_is_ctrl_out <= 1'b0;
      end else begin
        link_word_out <= 64'h0000_0000_0000_0000;
        link_word_out[tx_ctl_pkg::CTRL_FLAG_BIT] <= 1'b1;
        link_word_out[tx_ctl_pkg::BURST_FLAG_BIT] <=
          (state == tx_ctl_pkg::ST_BCTRL);
        link_word_out[tx_ctl_pkg::CAL_START_BIT] <= (cal_group == 4'h0);
        link_word_out[tx_ctl_pkg::CAL_HI_BIT:tx_ctl_pkg::CAL_LO_BIT] <=
          cal_bits;
        link_is_ctrl_out <= 1'b1;
      end
    end
  end
endmodule

// file: sim/tx_ctl_checker.sv
// ********
// Port checker
// ********
module tx_ctl_checker (
  input wire logic         clk_in,
  input wire logic         reset_n_in,
  input wire logic         avs_read_in,
  input wire logic         avs_write_in,
  input wire logic         avs_waitrequest_out,
  input wire logic [3:0]   segment_valid_in,
  input wire logic         user_ready_out,
  input wire logic         transmit_permit_in,
  input wire logic [255:0] flow_calendar_status_in,
  input wire logic [63:0]  link_word_out,
  input wire logic         link_is_ctrl_out,
  input wire logic         link_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic [3:0]   grp;
  logic [3:0]   dcnt;
  logic [255:0] cal_q;
  logic [15:0]  cal_exp;
  wire          cw = link_valid_out && link_is_ctrl_out;
  // Lowest entry of the group lands on the top bit
  assign cal_exp = {<<{cal_q[{grp, 4'h0} +: 16]}};
  // Group pointer and data words since the last control word
  always_ff @(posedge clk_in) begin
    cal_q <= flow_calendar_status_in;
    if (!reset_n_in) begin
      grp  <= 4'h0;
      dcnt <= 4'h0;
    end else if (cw) begin
      grp  <= grp + 4'h1;
      dcnt <= 4'h0;
    end else if (link_valid_out && dcnt != 4'hf) begin
      dcnt <= dcnt + 4'h1;
    end
  end
  chk_valid_steady: assert property (
    $past(reset_n_in) |-> link_valid_out) else $error("link valid dropped");
  chk_cal_start: assert property (
    cw |-> link_word_out[56] == (grp == 4'h0)) else $error("start bit");
  chk_cal_order: assert property (
    cw |-> link_word_out[55:40] == cal_exp) else $error("calendar bits");
  chk_permit_low: assert property (
    !transmit_permit_in [*3] |=> link_is_ctrl_out)
    else $error("data sent while halted");
  chk_burst_limit: assert property (
    link_valid_out && !link_is_ctrl_out |-> dcnt < 4'h8)
    else $error("burst too long");
  chk_wait_one: assert property (
    $rose(avs_read_in || avs_write_in) |->
      avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("wait state count");
  chk_ready_drop: assert property (
    user_ready_out && (|segment_valid_in) |=> !user_ready_out)
    else $error("ready held after take");
  chk_ctrl_marker: assert property (
    cw |-> link_word_out[63]) else $error("control marker");
endmodule
bind tx_control_word_insertion tx_ctl_checker tx_ctl_checker_i (
  .clk_in                  (clk_in),
  .reset_n_in              (reset_n_in),
  .avs_read_in             (avs_read_in),
  .avs_write_in            (avs_write_in),
  .avs_waitrequest_out     (avs_waitrequest_out),
  .segment_valid_in        (segment_valid_in),
  .user_ready_out          (user_ready_out),
  .transmit_permit_in      (transmit_permit_in),
  .flow_calendar_status_in (flow_calendar_status_in),
  .link_word_out           (link_word_out),
  .link_is_ctrl_out        (link_is_ctrl_out),
  .link_valid_out          (link_valid_out)
);

// file: sim/link_receiver.sv
// ********
// Far-end lane receiver model
// ********
module link_receiver (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [63:0] word_in,
  input  wire logic        is_ctrl_in,
  input  wire logic        valid_in,
  output logic             aligned_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [64:0] data_q[$];
  logic [63:0] start_word;
  logic [63:0] next_word;
  logic        prev_bc;
  logic        prev_start;
  int          ctrl_seen;
  // Keeps data words tagged with a preceding burst control word
  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_seen = 0;
      prev_bc = 1'b0;
      prev_start = 1'b0;
    end else if (valid_in) begin
      if (!is_ctrl_in) data_q.push_back({prev_bc, word_in});
      if (is_ctrl_in && prev_start) next_word = word_in;
      if (is_ctrl_in && word_in[56]) start_word = word_in;
      if (is_ctrl_in) prev_start = word_in[56];
      if (is_ctrl_in) ctrl_seen++;
      prev_bc = is_ctrl_in && word_in[61];
    end
    // Lock needs several control words; data before it would be lost
    aligned_out <= ctrl_seen >= 8;
  end
endmodule

// file: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_in;
  logic         reset_n_in;
  logic [3:0]   avs_address_in;
  logic         avs_read_in;
  logic         avs_write_in;
  logic [31:0]  avs_writedata_in;
  logic [31:0]  avs_readdata_out;
  logic         avs_waitrequest_out;
  logic [3:0]   segment_valid_in;
  logic [255:0] segment_payload_in;
  logic [3:0]   force_bc;
  logic         user_ready_out;
  logic         transmit_permit_in;
  logic [255:0] flow_calendar_status_in;
  logic [63:0]  link_word_out;
  logic         link_is_ctrl_out;
  logic         link_valid_out;
  logic         aligned;
  logic [31:0]  q;
  int           n_mismatch;
  int           comparisons;
  tx_control_word_insertion tx_control_word_insertion_i (.*,
    .avs_byteenable_in       (4'hf),
    .force_burst_ctrl_seg0_in(force_bc[0]),
    .force_burst_ctrl_seg1_in(force_bc[1]),
    .force_burst_ctrl_seg2_in(force_bc[2]),
    .force_burst_ctrl_seg3_in(force_bc[3]));
  link_receiver link_receiver_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .word_in(link_word_out), .is_ctrl_in(link_is_ctrl_out),
    .valid_in(link_valid_out), .aligned_out(aligned));
  // ********
  // Helpers
  // ********
  function automatic logic [63:0] word(input logic [7:0] k, input int i);
    return {48'hc0de_5eed_0000, k, 8'(i)};
  endfunction
  // Calendar field order: lowest entry of a group on the top bit
  function automatic logic [15:0] rev16(input logic [15:0] x);
    logic [15:0] r;
    for (int i = 0; i < 16; i++) r[i] = x[15 - i];
    return r;
  endfunction
  task automatic check(input string what, input logic [63:0] e, g);
    comparisons++;
    if (e !== g) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // Request held until an edge sees waitrequest low; that edge lands a
  // write and carries read data. Design outputs still show their
  // pre-edge values when this process wakes at the edge.
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk_in);
    avs_address_in   <= a;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    avs_writedata_in <= d;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic beat(input logic [3:0] f, input logic [7:0] k);
    @(negedge clk_in);
    link_receiver_i.data_q.delete();
    @(posedge clk_in);
    segment_valid_in <= 4'hf;
    force_bc         <= f;
    for (int i = 0; i < 4; i++) segment_payload_in[64*i +: 64] <= word(k, i);
    // Beat is taken at the edge that sees ready high
    do begin
      @(posedge clk_in);
    end while (user_ready_out !== 1'b1);
    segment_valid_in <= 4'h0;
    force_bc         <= 4'h0;
  endtask
  task automatic drain(input logic [3:0] f, input logic [7:0] k);
    for (int i = 0; i < 80 && link_receiver_i.data_q.size() < 4; i++)
      @(posedge clk_in);
    check("data count", 4, link_receiver_i.data_q.size());
    for (int i = 0; i < 4 && link_receiver_i.data_q.size() == 4; i++) begin
      check("segment", word(k, i), link_receiver_i.data_q[i][63:0]);
      if (f[i]) check("forced bc", 1, link_receiver_i.data_q[i][64]);
    end
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_regs;
    bus(1'b0, tx_ctl_pkg::REG_CTRL, 32'h0);
    check("ctrl reset", 32'h0000_0001, q);
    bus(1'b0, tx_ctl_pkg::REG_BURST_MAX, 32'h0);
    check("burst max reset", 32'h0000_0008, q);
    bus(1'b1, tx_ctl_pkg::REG_CTRL, 32'h0000_0000);
    bus(1'b0, tx_ctl_pkg::REG_CTRL, 32'h0);
    check("ctrl write", 32'h0000_0000, q);
    bus(1'b1, tx_ctl_pkg::REG_CTRL, 32'h0000_0001);
    bus(1'b1, 4'h1, 32'hffff_ffff);
    bus(1'b0, 4'h1, 32'h0);
    check("unmapped", tx_ctl_pkg::UNMAPPED_VALUE, q);
    bus(1'b0, tx_ctl_pkg::REG_STATUS, 32'h0);
    check("fifo empty", 1, q[tx_ctl_pkg::STAT_EMPTY_BIT]);
  endtask
  // Halted link must keep the queued segments until permit returns
  task automatic t_gate(input logic [7:0] k);
    @(posedge clk_in);
    transmit_permit_in <= 1'b0;
    beat(4'h0, k);
    repeat (20) @(posedge clk_in);
    check("held data", 0, link_receiver_i.data_q.size());
    bus(1'b0, tx_ctl_pkg::REG_STATUS, 32'h0);
    check("xoff flag", 1, q[tx_ctl_pkg::STAT_XOFF_BIT]);
    check("fifo full", 1, q[tx_ctl_pkg::STAT_FULL_BIT]);
    for (int i = 0; i < 200 && !aligned; i++) @(posedge clk_in);
    transmit_permit_in <= 1'b1;
    drain(4'h0, k);
  endtask
  task automatic t_force;
    for (int s = 0; s < 4; s++) begin
      beat(4'(1 << s), 8'(s + 1));
      drain(4'(1 << s), 8'(s + 1));
    end
  endtask
  // Short burst limit: third data word must follow a Burst Control word
  task automatic t_burst;
    bus(1'b1, tx_ctl_pkg::REG_BURST_MAX, 32'h0000_0002);
    beat(4'h0, 8'h30);
    drain(4'h0, 8'h30);
    check("bc at limit", 1, link_receiver_i.data_q[2][64]);
    check("no early bc", 0, link_receiver_i.data_q[1][64]);
    bus(1'b1, tx_ctl_pkg::REG_BURST_MAX, 32'h0000_0008);
  endtask
  task automatic t_cal;
    repeat (40) @(posedge clk_in);
    check("group 0", rev16(flow_calendar_status_in[15:0]),
          link_receiver_i.start_word[55:40]);
    check("group 1", rev16(flow_calendar_status_in[31:16]),
          link_receiver_i.next_word[55:40]);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Free-running 200 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Cuts a hang; the whole run needs well under 3000 cycles
  initial begin
    repeat (6000) @(posedge clk_in);
    n_mismatch++;
    final_report;
  end
  // Main sequence
  initial begin
    reset_n_in = 1'b0;
    avs_address_in = 4'h0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    segment_valid_in = 4'h0;
    segment_payload_in = '0;
    force_bc = 4'h0;
    transmit_permit_in = 1'b0;
    for (int g = 0; g < 16; g++)
      flow_calendar_status_in[16*g +: 16] = {4'(g), 12'h5a3};
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    t_regs;
    t_gate(8'h10);
    t_force;
    t_burst;
    t_gate(8'h20);
    t_cal;
    final_report;
  end
endmodule
